// file: watchdog_service_and_irq_priority_test.sv
`timescale 1ns/1ps
`include "wsp_params.svh"
module watchdog_service_and_irq_priority_test import wsp_pkg::*;;
    logic sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [15:0] avs_address = 16'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
    logic [3:0] avs_byteenable = 4'hf, top_src_id;
    logic avs_waitrequest, strap_a = 1'b0, strap_b = 1'b0, ccr_int_mask, mask_cmd = 1'b1;
    logic [WSP_NSRC-1:0] src_req, req_cmd = '0;
    logic top_src_valid, wd_reset_req, irq;
    int error_cnt = 0, cmp_count = 0, n;
    typedef struct {logic [3:0] code; wsp_src_e id;} wsp_row_s;
    wsp_row_s rows [16] = '{'{4'h0, WSP_SRC_TOF}, '{4'h1, WSP_SRC_PAOV}, '{4'h2, WSP_SRC_PAI},
        '{4'h3, WSP_SRC_IRQ}, '{4'h4, WSP_SRC_SCI}, '{4'h5, WSP_SRC_IRQ}, '{4'h6, WSP_SRC_IRQ},
        '{4'h7, WSP_SRC_RTI}, '{4'h8, WSP_SRC_IC1}, '{4'h9, WSP_SRC_IC2}, '{4'ha, WSP_SRC_IC3},
        '{4'hb, WSP_SRC_OC1}, '{4'hc, WSP_SRC_OC2}, '{4'hd, WSP_SRC_OC3}, '{4'he, WSP_SRC_OC4},
        '{4'hf, WSP_SRC_IC4OC5}};
    logic [7:0] strap_exp [4] = '{8'hc5, 8'h65, 8'h05, 8'h25};
    always #10 sys_clk = ~sys_clk;
    wsp_top #(.WD_TMO0(32'h10), .WD_TMO1(32'h20), .WD_TMO2(32'h40), .WD_TMO3(32'h80)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mode_strap_a(strap_a), .mode_strap_b(strap_b), .ccr_int_mask(ccr_int_mask),
        .src_req(src_req), .top_src_valid(top_src_valid), .top_src_id(top_src_id),
        .wd_reset_req(wd_reset_req), .irq(irq));
    wsp_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .mask_cmd(mask_cmd),
        .req_cmd(req_cmd), .ccr_int_mask(ccr_int_mask), .src_req(src_req));
    function automatic logic [15:0] ad(input logic [13:0] i);
        return {i, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [13:0] i, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= ad(i);
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        // Only the bench watchdog ends a wait that never gets an answer
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] s);
        @(posedge sys_clk);
        {strap_b, strap_a} <= s;
        sys_rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1_000_000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        // Mode bits follow straps at every reset
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            bus(1'b0, `WSP_IDX_PRIO, 8'h0);
            chk(rdata, {24'h0, strap_exp[s]});
        end
        // Normal mode keeps mode bits, flags refusal
        do_reset(2'b10);
        bus(1'b1, `WSP_IDX_STATUS, 8'h0f);
        bus(1'b1, `WSP_IDX_PRIO, 8'hf3);
        bus(1'b0, `WSP_IDX_PRIO, 8'h0);
        chk(rdata, 32'h13);
        bus(1'b0, `WSP_IDX_STATUS, 8'h0);
        chk(rdata & 32'h8, 32'h8);
        do_reset(2'b00);
        bus(1'b1, `WSP_IDX_PRIO, 8'ha5);
        bus(1'b0, `WSP_IDX_PRIO, 8'h0);
        chk(rdata, 32'ha5);
        do_reset(2'b00);
        bus(1'b0, `WSP_IDX_WDCTL, 8'h0);
        chk(rdata, 32'h04);
        bus(1'b0, `WSP_IDX_MASK, 8'h0);
        chk(rdata, 32'h0);
        // Write with low byte lane disabled is ignored
        avs_byteenable <= 4'he;
        bus(1'b1, `WSP_IDX_MASK, 8'h0f);
        avs_byteenable <= 4'hf;
        bus(1'b0, `WSP_IDX_MASK, 8'h0);
        chk(rdata, 32'h0);
        bus(1'b0, `WSP_IDX_SERVICE, 8'h0);
        chk(rdata, 32'h0);
        bus(1'b1, 14'h0, 8'hff);
        bus(1'b0, 14'h0, 8'h0);
        chk(rdata, 32'h0);
        // All sources requesting, promoted one wins
        req_cmd <= '1;
        for (int r = 0; r < 16; r++) begin
            bus(1'b1, `WSP_IDX_PRIO, {4'hc, rows[r].code});
            bus(1'b0, `WSP_IDX_PRIO, 8'h0);
            chk(rdata, {24'h0, 4'hc, rows[r].code});
            chk(top_src_id, rows[r].id);
        end
        // Promoted idle, lowest requesting index wins
        bus(1'b1, `WSP_IDX_PRIO, 8'hc1);
        req_cmd <= 14'h3000;
        repeat (3) @(posedge sys_clk);
        chk(top_src_id, WSP_SRC_PAI);
        chk(top_src_valid, 1'b1);
        req_cmd <= '0;
        repeat (3) @(posedge sys_clk);
        chk(top_src_valid, 1'b0);
        mask_cmd <= 1'b0;
        bus(1'b1, `WSP_IDX_PRIO, 8'hc4);
        bus(1'b0, `WSP_IDX_PRIO, 8'h0);
        chk(rdata, 32'hc1);
        bus(1'b0, `WSP_IDX_STATUS, 8'h0);
        chk(rdata & 32'h4, 32'h4);
        mask_cmd <= 1'b1;
        bus(1'b1, `WSP_IDX_STATUS, 8'h0f);
        bus(1'b1, `WSP_IDX_SERVICE, `WSP_CLR_CODE);
        bus(1'b0, `WSP_IDX_STATUS, 8'h0);
        chk(rdata & 32'h2, 32'h0);
        bus(1'b1, `WSP_IDX_SERVICE, `WSP_ARM_CODE);
        bus(1'b0, `WSP_IDX_WDSTATE, 8'h0);
        chk(rdata, 32'h1);
        bus(1'b1, `WSP_IDX_SERVICE, `WSP_ARM_CODE);
        bus(1'b1, `WSP_IDX_SERVICE, 8'h12);
        bus(1'b0, `WSP_IDX_WDSTATE, 8'h0);
        chk(rdata, 32'h1);
        bus(1'b1, `WSP_IDX_SERVICE, `WSP_CLR_CODE);
        bus(1'b0, `WSP_IDX_WDSTATE, 8'h0);
        chk(rdata, 32'h0);
        bus(1'b0, `WSP_IDX_STATUS, 8'h0);
        chk(rdata & 32'h2, 32'h2);
        // Timeout per rate code, counted from service
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, `WSP_IDX_WDCTL, {6'h1, c[1:0]});
            bus(1'b1, `WSP_IDX_SERVICE, `WSP_ARM_CODE);
            bus(1'b1, `WSP_IDX_SERVICE, `WSP_CLR_CODE);
            n = 0;
            while (wd_reset_req !== 1'b1 && n < 400) begin
                @(posedge sys_clk);
                n++;
            end
            chk(n, (16 << c) + 2);
        end
        // Timeout raises irq only when unmasked, W1C clears it
        chk(irq, 1'b0);
        bus(1'b1, `WSP_IDX_MASK, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        bus(1'b1, `WSP_IDX_WDCTL, 8'h00);
        repeat (4) @(posedge sys_clk);
        bus(1'b1, `WSP_IDX_STATUS, 8'h0f);
        bus(1'b0, `WSP_IDX_STATUS, 8'h0);
        chk(rdata, 32'h0);
        chk(irq, 1'b0);
        report_and_stop();
    end
endmodule // watchdog_service_and_irq_priority_test

// file: wsp_core_model.sv
`timescale 1ns/1ps
module wsp_core_model import wsp_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic mask_cmd,
    input wire logic [WSP_NSRC-1:0] req_cmd,
    output logic ccr_int_mask,
    output logic [WSP_NSRC-1:0] src_req
);
    logic next_mask;
    logic [WSP_NSRC-1:0] next_req;
    always_comb begin
        next_mask = mask_cmd;
        next_req = req_cmd;
        // Core comes out of reset with interrupts masked
        if (sys_rst) begin
            next_mask = 1'b1;
            next_req = '0;
        end
    end
    always_ff @(posedge sys_clk) begin
        ccr_int_mask <= next_mask;
        src_req <= next_req;
    end
endmodule // wsp_core_model

// file: wsp_params.svh
`ifndef WSP_PARAMS_SVH
`define WSP_PARAMS_SVH

// Register indices; byte address is four times the index
`define WSP_IDX_SERVICE 14'h103a
`define WSP_IDX_PRIO 14'h103c
`define WSP_IDX_WDCTL 14'h1040
`define WSP_IDX_STATUS 14'h1041
`define WSP_IDX_MASK 14'h1042
`define WSP_IDX_WDSTATE 14'h1043

// Watchdog service codes
`define WSP_ARM_CODE 8'h55
`define WSP_CLR_CODE 8'haa

// Top priority register fields
`define WSP_BIT_BOOT 7
`define WSP_BIT_SPECIAL_MODE_SEL 6
`define WSP_BIT_MDA 5
`define WSP_BIT_READ_VISIBILITY_E_CTL 4
`define WSP_PSEL_RST 4'h5
`define WSP_READ_VISIBILITY_E_CTL_RST 1'b0

// Watchdog control fields
`define WSP_BIT_WDEN 2
`define WSP_RATE_RST 2'h0
`define WSP_WDEN_RST 1'b1

// Interrupt status and mask bits
`define WSP_ST_TIMEOUT 0
`define WSP_ST_SERVICED 1
`define WSP_ST_PRIO_REFUSED 2
`define WSP_ST_MODE_REFUSED 3
`define WSP_ST_RST 4'h0
`define WSP_MASK_RST 4'h0

// Watchdog timeouts in E-clock cycles, E equal to sys_clk
`define WSP_TMO0 32'h0000_8000
`define WSP_TMO1 32'h0002_0000
`define WSP_TMO2 32'h0008_0000
`define WSP_TMO3 32'h0020_0000

`endif

// file: wsp_pkg.sv
package wsp_pkg;

    typedef logic [7:0] wsp_byte_t;

    typedef enum logic {
        WSP_DISARMED = 1'b0,
        WSP_ARMED = 1'b1
    } wsp_arm_e;

    // Maskable sources, listed in their default priority order
    typedef enum logic [3:0] {
        WSP_SRC_IRQ = 4'h0,
        WSP_SRC_RTI = 4'h1,
        WSP_SRC_IC1 = 4'h2,
        WSP_SRC_IC2 = 4'h3,
        WSP_SRC_IC3 = 4'h4,
        WSP_SRC_OC1 = 4'h5,
        WSP_SRC_OC2 = 4'h6,
        WSP_SRC_OC3 = 4'h7,
        WSP_SRC_OC4 = 4'h8,
        WSP_SRC_IC4OC5 = 4'h9,
        WSP_SRC_TOF = 4'ha,
        WSP_SRC_PAOV = 4'hb,
        WSP_SRC_PAI = 4'hc,
        WSP_SRC_SCI = 4'hd
    } wsp_src_e;

    localparam int WSP_NSRC = 14;

endpackage

// file: wsp_top.sv
`timescale 1ns/1ps
`include "wsp_params.svh"
// Functional notes
// RULE_01 - Writing 0x55 to the watchdog service register arms the service sequence.
// RULE_02 - Writing 0xaa after arming restarts the watchdog count from zero.
// RULE_03 - Only 0xaa following an arming 0x55 services; other values do nothing, 0x55 re-arms.
// RULE_04 - Rate codes 00..11 give timeouts of 2^15, 2^17, 2^19 and 2^21 E-clock cycles.
// RULE_05 - An elapsed timeout raises a watchdog failure reset request.
// RULE_06 - Boot, special-mode and mode-A bits ignore writes outside special mode.
// RULE_07 - Those three bits reset to values decoded from the power-up mode straps.
// RULE_08 - The priority-select field takes writes only while the interrupt mask bit is set.
// RULE_09 - The selected source is resolved ahead of every other maskable source.
// RULE_10 - Low codes 000, 001, 010, 100 pick timer overflow, pulse overflow, pulse edge, serial.
// RULE_11 - Low code 011 is reserved and promotes the external interrupt pin.
// RULE_12 - Low codes 110 and 111 pick the pin and real-time tick; the upper group picks capture.
module wsp_top import wsp_pkg::*; #(
    parameter logic [31:0] WD_TMO0 = `WSP_TMO0,
    parameter logic [31:0] WD_TMO1 = `WSP_TMO1,
    parameter logic [31:0] WD_TMO2 = `WSP_TMO2,
    parameter logic [31:0] WD_TMO3 = `WSP_TMO3
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mode_strap_a,
    input wire logic mode_strap_b,
    input wire logic ccr_int_mask,
    input wire logic [WSP_NSRC-1:0] src_req,
    output logic top_src_valid,
    output logic [3:0] top_src_id,
    output logic wd_reset_req,
    output logic irq
);
    // Strap synchronisers, left free-running so they track pins during reset
    logic strap_a_s1;
    logic strap_a_s2;
    logic strap_b_s1;
    logic strap_b_s2;

    logic done;
    logic next_done;
    logic next_waitrequest;
    logic [31:0] next_readdata;

    wsp_arm_e arm_st;
    wsp_arm_e next_arm_st;
    logic clr_pulse;
    logic next_clr_pulse;
    logic [1:0] rate;
    logic [1:0] next_rate;
    logic wd_en;
    logic next_wd_en;

    logic boot_rom_visible;
    logic next_boot_rom_visible;
    logic special_mode_sel;
    logic next_special_mode_sel;
    logic mode_select_a;
    logic next_mode_select_a;
    logic read_visibility_e_ctl;
    logic next_read_visibility_e_ctl;
    logic [3:0] psel;
    logic [3:0] next_psel;

    logic [3:0] status;
    logic [3:0] next_status;
    logic [3:0] mask;
    logic [3:0] next_mask;
    logic next_irq;
    logic next_wd_reset_req;
    logic next_top_src_valid;
    logic [3:0] next_top_src_id;

    logic acc;
    logic wr_acc;
    logic [7:0] wdat;
    logic hit_service;
    logic hit_prio;
    logic hit_wdctl;
    logic hit_status;
    logic hit_mask;
    logic hit_wdstate;
    logic strap_boot;
    logic strap_special_mode_sel;
    logic strap_mda;
    logic [3:0] events;
    wsp_src_e promoted;
    logic [3:0] lowest;
    logic found;
    logic [7:0] prio_rd;

    wsp_wd_if wd_bus ();

    assign wd_bus.clear = clr_pulse;
    assign wd_bus.enable = wd_en;
    assign wd_bus.rate = rate;

    wsp_wdog #(
        .TMO0(WD_TMO0),
        .TMO1(WD_TMO1),
        .TMO2(WD_TMO2),
        .TMO3(WD_TMO3)
    ) u_wdog (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wd(wd_bus.wdog)
    );

    always_ff @(posedge sys_clk) begin
        strap_a_s1 <= mode_strap_a;
        strap_a_s2 <= strap_a_s1;
        strap_b_s1 <= mode_strap_b;
        strap_b_s2 <= strap_b_s1;
    end

    // RULE_07 - mode decoded from straps
    always_comb begin
        strap_boot = !strap_b_s2 && !strap_a_s2;
        strap_special_mode_sel = !strap_b_s2;
        strap_mda = strap_a_s2;
    end

    // Bus decode; one access per request, answered on the second edge
    always_comb begin
        acc = (avs_read || avs_write) && !done;
        wr_acc = avs_write && !done && avs_byteenable[0];
        wdat = avs_writedata[7:0];
        hit_service = avs_address == {`WSP_IDX_SERVICE, 2'b00};
        hit_prio = avs_address == {`WSP_IDX_PRIO, 2'b00};
        hit_wdctl = avs_address == {`WSP_IDX_WDCTL, 2'b00};
        hit_status = avs_address == {`WSP_IDX_STATUS, 2'b00};
        hit_mask = avs_address == {`WSP_IDX_MASK, 2'b00};
        hit_wdstate = avs_address == {`WSP_IDX_WDSTATE, 2'b00};
        prio_rd = {boot_rom_visible, special_mode_sel, mode_select_a,
                   read_visibility_e_ctl, psel};
    end

    // Promoted source lookup
    always_comb begin
        case (psel)
            // RULE_10 - lower group sources
            4'b0000: promoted = WSP_SRC_TOF;
            4'b0001: promoted = WSP_SRC_PAOV;
            4'b0010: promoted = WSP_SRC_PAI;
            // RULE_11 - reserved falls to pin
            4'b0011: promoted = WSP_SRC_IRQ;
            4'b0100: promoted = WSP_SRC_SCI;
            4'b0101: promoted = WSP_SRC_IRQ;
            // RULE_12 - pin, tick, capture group
            4'b0110: promoted = WSP_SRC_IRQ;
            4'b0111: promoted = WSP_SRC_RTI;
            4'b1000: promoted = WSP_SRC_IC1;
            4'b1001: promoted = WSP_SRC_IC2;
            4'b1010: promoted = WSP_SRC_IC3;
            4'b1011: promoted = WSP_SRC_OC1;
            4'b1100: promoted = WSP_SRC_OC2;
            4'b1101: promoted = WSP_SRC_OC3;
            4'b1110: promoted = WSP_SRC_OC4;
            4'b1111: promoted = WSP_SRC_IC4OC5;
            default: promoted = WSP_SRC_IRQ;
        endcase
    end

    // Fixed order among the rest: lower index wins
    always_comb begin
        lowest = 4'h0;
        found = 1'b0;
        for (int i = WSP_NSRC - 1; i >= 0; i--) begin
            if (src_req[i]) begin
                lowest = 4'(i);
                found = 1'b1;
            end
        end
    end

    always_comb begin
        next_done = acc;
        next_waitrequest = !acc;
        next_readdata = avs_readdata;
        next_arm_st = arm_st;
        next_clr_pulse = 1'b0;
        next_rate = rate;
        next_wd_en = wd_en;
        next_boot_rom_visible = boot_rom_visible;
        next_special_mode_sel = special_mode_sel;
        next_mode_select_a = mode_select_a;
        next_read_visibility_e_ctl = read_visibility_e_ctl;
        next_psel = psel;
        next_mask = mask;
        events = 4'h0;

        if (acc && avs_read) begin
            next_readdata = 32'h0;
            if (hit_prio) begin
                next_readdata = {24'h0, prio_rd};
            end else if (hit_wdctl) begin
                next_readdata = {29'h0, wd_en, rate};
            end else if (hit_status) begin
                next_readdata = {28'h0, status};
            end else if (hit_mask) begin
                next_readdata = {28'h0, mask};
            end else if (hit_wdstate) begin
                next_readdata = {31'h0, arm_st == WSP_ARMED};
            end
        end

        if (wr_acc && hit_service) begin
            case (arm_st)
                WSP_DISARMED: begin
                    // RULE_01 - arming code
                    if (wdat == `WSP_ARM_CODE) begin
                        next_arm_st = WSP_ARMED;
                    end
                end
                WSP_ARMED: begin
                    // RULE_03 - clear only when armed
                    if (wdat == `WSP_CLR_CODE) begin
                        next_arm_st = WSP_DISARMED;
                        next_clr_pulse = 1'b1;
                        events[`WSP_ST_SERVICED] = 1'b1;
                    end
                end
                default: next_arm_st = WSP_DISARMED;
            endcase
        end

        if (wr_acc && hit_prio) begin
            next_read_visibility_e_ctl = wdat[`WSP_BIT_READ_VISIBILITY_E_CTL];
            // RULE_06 - mode bits special only
            if (special_mode_sel) begin
                next_boot_rom_visible = wdat[`WSP_BIT_BOOT];
                next_special_mode_sel = wdat[`WSP_BIT_SPECIAL_MODE_SEL];
                next_mode_select_a = wdat[`WSP_BIT_MDA];
            end else if (wdat[7:5] != prio_rd[7:5]) begin
                events[`WSP_ST_MODE_REFUSED] = 1'b1;
            end
            // RULE_08 - priority needs mask set
            if (ccr_int_mask) begin
                next_psel = wdat[3:0];
            end else begin
                events[`WSP_ST_PRIO_REFUSED] = 1'b1;
            end
        end

        if (wr_acc && hit_wdctl) begin
            next_rate = wdat[1:0];
            next_wd_en = wdat[`WSP_BIT_WDEN];
        end
        if (wr_acc && hit_mask) begin
            next_mask = wdat[3:0];
        end

        events[`WSP_ST_TIMEOUT] = wd_bus.timeout;
        // Set wins over a simultaneous write-one clear
        next_status = status & ~((wr_acc && hit_status) ? wdat[3:0] : 4'h0);
        next_status = next_status | events;
        next_irq = |(next_status & next_mask);

        // RULE_05 - failure reset request
        next_wd_reset_req = wd_bus.timeout;

        // RULE_09 - promoted source first
        next_top_src_valid = found;
        next_top_src_id = src_req[promoted] ? promoted : lowest;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            arm_st <= WSP_DISARMED;
            clr_pulse <= 1'b0;
            rate <= `WSP_RATE_RST;
            wd_en <= `WSP_WDEN_RST;
            // RULE_07 - straps load mode bits
            boot_rom_visible <= strap_boot;
            special_mode_sel <= strap_special_mode_sel;
            mode_select_a <= strap_mda;
            read_visibility_e_ctl <= `WSP_READ_VISIBILITY_E_CTL_RST;
            psel <= `WSP_PSEL_RST;
            status <= `WSP_ST_RST;
            mask <= `WSP_MASK_RST;
            irq <= 1'b0;
            wd_reset_req <= 1'b0;
            top_src_valid <= 1'b0;
            top_src_id <= 4'h0;
        end else begin
            done <= next_done;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
            arm_st <= next_arm_st;
            clr_pulse <= next_clr_pulse;
            rate <= next_rate;
            wd_en <= next_wd_en;
            boot_rom_visible <= next_boot_rom_visible;
            special_mode_sel <= next_special_mode_sel;
            mode_select_a <= next_mode_select_a;
            read_visibility_e_ctl <= next_read_visibility_e_ctl;
            psel <= next_psel;
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
            wd_reset_req <= next_wd_reset_req;
            top_src_valid <= next_top_src_valid;
            top_src_id <= next_top_src_id;
        end
    end

    arm_on_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_01
        wr_acc && hit_service && wdat == `WSP_ARM_CODE |=> arm_st == WSP_ARMED && !clr_pulse)
        else $error("Arming code did not arm");

    clear_when_armed_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_02
        wr_acc && hit_service && wdat == `WSP_CLR_CODE && arm_st == WSP_ARMED
        |=> clr_pulse ##1 !clr_pulse)
        else $error("Clear code after arming did not service");

    only_armed_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_03
        clr_pulse |-> $past(arm_st) == WSP_ARMED && $past(wdat) == `WSP_CLR_CODE
        && arm_st == WSP_DISARMED)
        else $error("Watchdog serviced without arm sequence");

    fail_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_05
        wd_bus.timeout |=> wd_reset_req && status[`WSP_ST_TIMEOUT])
        else $error("Timeout gave no reset request");

    mode_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_06
        wr_acc && hit_prio && !special_mode_sel
        |=> $stable(boot_rom_visible) && $stable(special_mode_sel) && $stable(mode_select_a))
        else $error("Mode bits changed outside special mode");

    strap_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_07
        $past(sys_rst) |-> special_mode_sel == $past(strap_special_mode_sel)
        && mode_select_a == $past(strap_mda) && boot_rom_visible == $past(strap_boot))
        else $error("Mode bits not loaded from straps");

    psel_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_08
        wr_acc && hit_prio && !ccr_int_mask |=> $stable(psel) && status[`WSP_ST_PRIO_REFUSED])
        else $error("Priority field written with mask clear");

    promote_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_09
        src_req[promoted] |=> top_src_valid && top_src_id == $past(promoted))
        else $error("Promoted source not resolved first");

endmodule // wsp_top

// file: wsp_wd_if.sv
`timescale 1ns/1ps
interface wsp_wd_if;
    logic clear;
    logic enable;
    logic [1:0] rate;
    logic timeout;

    modport ctl (output clear, output enable, output rate, input timeout);
    modport wdog (input clear, input enable, input rate, output timeout);
endinterface // wsp_wd_if

// file: wsp_wdog.sv
`timescale 1ns/1ps
`include "wsp_params.svh"
module wsp_wdog import wsp_pkg::*; #(
    parameter logic [31:0] TMO0 = `WSP_TMO0,
    parameter logic [31:0] TMO1 = `WSP_TMO1,
    parameter logic [31:0] TMO2 = `WSP_TMO2,
    parameter logic [31:0] TMO3 = `WSP_TMO3
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    wsp_wd_if.wdog wd
);
    logic [21:0] cnt;
    logic [21:0] next_cnt;
    logic timeout;
    logic next_timeout;
    logic [31:0] limit;

    assign wd.timeout = timeout;

    always_comb begin
        // RULE_04 - rate selects timeout
        case (wd.rate)
            2'b00: limit = TMO0;
            2'b01: limit = TMO1;
            2'b10: limit = TMO2;
            default: limit = TMO3;
        endcase
        next_cnt = cnt + 22'h1;
        next_timeout = 1'b0;
        // RULE_02 - service restarts count
        if (!wd.enable || wd.clear) begin
            next_cnt = 22'h0;
        end else if ({10'h0, cnt} == limit - 32'h1) begin
            next_cnt = 22'h0;
            next_timeout = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt <= 22'h0;
            timeout <= 1'b0;
        end else begin
            cnt <= next_cnt;
            timeout <= next_timeout;
        end
    end

    wd_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_04
        timeout |-> {10'h0, $past(cnt)} == $past(limit) - 32'h1 && $past(wd.enable))
        else $error("Watchdog timeout at wrong count");

    wd_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_02
        wd.clear |=> cnt == 22'h0 && !timeout)
        else $error("Watchdog count not restarted by service");

endmodule // wsp_wdog
